/* design/sfc_pkg.sv */
package sfc_pkg;
  // ---------------------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CHARS   = 8'h04;
  localparam logic [7:0] ADDR_PWAIT   = 8'h08;
  localparam logic [7:0] ADDR_RTSOFF  = 8'h0C;
  localparam logic [7:0] ADDR_OUTWAIT = 8'h10;
  localparam logic [7:0] ADDR_FLIM    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_FRAME   = 8'h1C;
  localparam logic [7:0] ADDR_RESTART = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_IFC_LSB  = 2;
  localparam int CTRL_DATA8    = 4;
  localparam int CTRL_FLUSH    = 5;
  localparam int CTRL_PROT     = 6;
  localparam int CHARS_XOFF_LSB = 8;
  localparam int ST_PAUSED     = 8;
  localparam int ST_RTS        = 9;
  localparam int ST_LOST       = 10;
  localparam int ST_TMO        = 11;
  localparam int ST_STATE_LSB  = 12;
  localparam int FRAME_VALID   = 8;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FC_NONE = 2'h0, FC_XON = 2'h1, FC_RTSCTS = 2'h2, FC_AUTO = 2'h3
  } sfc_mode_t;

  typedef enum logic [1:0] {
    IFC_RS232 = 2'h0, IFC_RS422 = 2'h1, IFC_RS485 = 2'h2
  } sfc_ifc_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RTS_WAIT = 3'h1, ST_SEND = 3'h3, ST_HOLD = 3'h2, ST_RTS_OFF = 3'h7
  } sfc_state_t;

  // ---------------------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  XON_RST      = 8'h11;
  localparam logic [7:0]  XOFF_RST     = 8'h13;
  localparam logic [7:0]  MASK7        = 8'h7F;
  localparam int          STEP_MS      = 10;
  localparam int          CLK_KHZ      = 50000;
  localparam int          TICK_CYC_DEF = STEP_MS * CLK_KHZ;
  localparam logic [12:0] PWAIT_MIN    = 13'h0002;
  localparam logic [12:0] STEPS_MAX    = 13'h1999;
  localparam logic [12:0] PWAIT_RST    = 13'h0002;
  localparam logic [12:0] RTSOFF_RST   = 13'h0000;
  localparam logic [12:0] OUTWAIT_RST  = 13'h0000;
  localparam logic [7:0]  FRAME_MAX    = 8'hFA;
  localparam logic [7:0]  FRAME_MIN    = 8'h01;
  localparam int          FRAME_W      = 8;
endpackage

/* design/sfc_flow_rxbuf.sv */
`timescale 1ns/1ns
// Notes on behaviour
// RL1: RS 485 port never applies flow control, whatever mode is configured.
// RL2: RTS/CTS and automatic signal control act only on RS 232C.
// RL3: Flow mode is none, XON/XOFF, RTS/CTS or automatic; none after reset.
// RL4: XON and XOFF codes limited to 7FH with seven data bits, else FFH.
// RL5: Paused sender waits for XON or CTS, 20 to 65530 ms, default 20 ms.
// RL6: Partner wait time applies only in XON/XOFF or RTS/CTS mode.
// RL7: Automatic mode holds RTS for a delay after transfer, default 0 ms.
// RL8: Automatic mode raises RTS, waits bounded time for CTS before sending.
// RL9: Partner answers RTS with CTS so transmission may begin.
// RL10: Startup flushes the receive buffer when enabled, else keeps frames.
// RL11: Buffered frames go to the host oldest first.
// RL12: Buffered frame count limited to 1..250, default 250.
// RL13: Overwrite protection on by default; off only allowed with limit 1.
// RL14: One-frame unprotected buffer always delivers the newest frame.
// RL15: Characters carry seven or eight data bits as configured.
// RL16: In XON/XOFF mode XOFF suspends sending until XON arrives.
// RL17: Full protected buffer discards new frames, keeps the old ones.
module sfc_flow_rxbuf #(
  parameter int TICK_CYCLES = sfc_pkg::TICK_CYC_DEF
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [7:0]                  addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [31:0]                 rdata,
  input  wire logic                        tx_start,
  input  wire logic                        tx_done,
  input  wire logic                        rx_char_valid,
  input  wire logic [7:0]                  rx_char,
  input  wire logic                        rx_frame_valid,
  input  wire logic [sfc_pkg::FRAME_W-1:0] rx_frame_data,
  input  wire logic                        cts_in,
  output logic                             rts_out,
  output logic                             tx_allow,
  output logic                             tx_timeout
);
  import sfc_pkg::*;

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Ring pointer advance, wraps at the largest frame count
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p == FRAME_MAX - 8'h01) ? 8'h00 : p + 8'h01;
  endfunction

  // Restrict a character to the configured data width
  function automatic logic [7:0] char_mask(input logic [7:0] c, input logic d8);
    char_mask = d8 ? c : (c & MASK7);
  endfunction

  // Clamp a step count to the legal range
  function automatic logic [12:0] steps_clamp(input logic [12:0] v, input logic [12:0] lo);
    steps_clamp = (v < lo) ? lo : ((v > STEPS_MAX) ? STEPS_MAX : v);
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  sfc_mode_t   mode_reg;
  sfc_ifc_t    ifc_reg;
  logic        data8_reg;
  logic        flush_reg;
  logic        prot_reg;
  logic [7:0]  xon_reg;
  logic [7:0]  xoff_reg;
  logic [12:0] pwait_reg;
  logic [12:0] rtsoff_reg;
  logic [12:0] outwait_reg;
  logic [7:0]  flim_reg;
  logic        lost_reg;
  logic        tmo_reg;

  logic wr_ctrl;
  logic wr_chars;
  assign wr_ctrl  = wr_stb && (addr == ADDR_CTRL);
  assign wr_chars = wr_stb && (addr == ADDR_CHARS);

  // Control word and timing fields
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg    <= FC_NONE; // RL3
      ifc_reg     <= IFC_RS232;
      data8_reg   <= 1'b1;
      flush_reg   <= 1'b1; // RL10
      prot_reg    <= 1'b1; // RL13
      pwait_reg   <= PWAIT_RST; // RL5
      rtsoff_reg  <= RTSOFF_RST; // RL7
      outwait_reg <= OUTWAIT_RST; // RL8
      flim_reg    <= FRAME_MAX; // RL12
    end else if (wr_stb) begin
      if (addr == ADDR_CTRL) begin
        mode_reg  <= sfc_mode_t'(wdata[CTRL_MODE_LSB +: 2]);
        ifc_reg   <= (wdata[CTRL_IFC_LSB +: 2] == 2'h3) ? IFC_RS485 : sfc_ifc_t'(wdata[CTRL_IFC_LSB +: 2]);
        data8_reg <= wdata[CTRL_DATA8];
        flush_reg <= wdata[CTRL_FLUSH];
        prot_reg  <= wdata[CTRL_PROT];
      end else if (addr == ADDR_PWAIT) begin
        pwait_reg <= steps_clamp(wdata[12:0], PWAIT_MIN); // RL5
      end else if (addr == ADDR_RTSOFF) begin
        rtsoff_reg <= steps_clamp(wdata[12:0], 13'h0000); // RL7
      end else if (addr == ADDR_OUTWAIT) begin
        outwait_reg <= steps_clamp(wdata[12:0], 13'h0000); // RL8
      end else if (addr == ADDR_FLIM) begin
        flim_reg <= (wdata[7:0] < FRAME_MIN) ? FRAME_MIN : ((wdata[7:0] > FRAME_MAX) ? FRAME_MAX : wdata[7:0]); // RL12
      end
    end
  end

  // Handshake codes, trimmed to seven bits when the frame has seven data bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      xon_reg  <= XON_RST;
      xoff_reg <= XOFF_RST;
    end else if (wr_chars) begin
      xon_reg  <= char_mask(wdata[7:0], data8_reg); // RL4
      xoff_reg <= char_mask(wdata[CHARS_XOFF_LSB +: 8], data8_reg); // RL4
    end else if (wr_ctrl && !wdata[CTRL_DATA8]) begin
      xon_reg  <= char_mask(xon_reg, 1'b0); // RL15
      xoff_reg <= char_mask(xoff_reg, 1'b0); // RL15
    end
  end

  // ---------------------------------------------------------------------------
  // Effective flow mode
  // ---------------------------------------------------------------------------
  sfc_mode_t eff_mode;
  always_comb begin
    if (ifc_reg == IFC_RS485) begin
      eff_mode = FC_NONE; // RL1
    end else if ((mode_reg == FC_RTSCTS || mode_reg == FC_AUTO) && ifc_reg != IFC_RS232) begin
      eff_mode = FC_NONE; // RL2
    end else begin
      eff_mode = mode_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // 10 ms timebase
  // ---------------------------------------------------------------------------
  logic [19:0] tick_cnt_reg;
  logic        tick;
  assign tick = (tick_cnt_reg == 20'(TICK_CYCLES - 1));

  // Free running step prescaler
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 20'h00000;
    end else begin
      tick_cnt_reg <= tick ? 20'h00000 : tick_cnt_reg + 20'h00001;
    end
  end

  // ---------------------------------------------------------------------------
  // XON/XOFF receive detection
  // ---------------------------------------------------------------------------
  logic paused_reg;
  logic [7:0] rx_c;
  assign rx_c = char_mask(rx_char, data8_reg);

  // Partner pause flag, XOFF sets and XON clears
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      paused_reg <= 1'b0;
    end else if (eff_mode != FC_XON) begin
      paused_reg <= 1'b0;
    end else if (rx_char_valid && rx_c == xoff_reg) begin
      paused_reg <= 1'b1; // RL16
    end else if (rx_char_valid && rx_c == xon_reg) begin
      paused_reg <= 1'b0; // RL16
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit flow state machine
  // ---------------------------------------------------------------------------
  sfc_state_t  state_reg;
  sfc_state_t  state_next;
  logic [12:0] wcnt_reg;
  logic [12:0] wcnt_next;
  logic        expire;
  logic        tmo_next;
  logic        rts_next;
  logic        stop_cond;
  assign expire    = (wcnt_reg == 13'h0000);
  assign stop_cond = (eff_mode == FC_XON && paused_reg) || (eff_mode == FC_RTSCTS && !cts_in);

  // Next state, wait counter and RTS level
  always_comb begin
    state_next = state_reg;
    wcnt_next  = (tick && !expire) ? wcnt_reg - 13'h0001 : wcnt_reg;
    tmo_next   = 1'b0;
    rts_next   = rts_out;
    case (state_reg)
      ST_IDLE: begin
        rts_next = (eff_mode == FC_RTSCTS);
        if (tx_start && eff_mode == FC_AUTO) begin
          rts_next   = 1'b1; // RL8
          wcnt_next  = outwait_reg;
          state_next = ST_RTS_WAIT;
        end else if (tx_start) begin
          state_next = ST_SEND;
        end
      end
      ST_RTS_WAIT: begin
        if (cts_in) begin
          state_next = ST_SEND; // RL8 RL9
        end else if (expire) begin
          tmo_next   = 1'b1; // RL8
          rts_next   = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_SEND: begin
        if (tx_done && eff_mode == FC_AUTO) begin
          wcnt_next  = rtsoff_reg; // RL7
          state_next = ST_RTS_OFF;
        end else if (tx_done) begin
          state_next = ST_IDLE;
        end else if (stop_cond) begin
          wcnt_next  = pwait_reg; // RL5 RL6
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!stop_cond) begin
          state_next = ST_SEND; // RL16
        end else if (expire) begin
          tmo_next   = 1'b1; // RL5
          state_next = ST_IDLE;
        end
      end
      ST_RTS_OFF: begin
        if (expire) begin
          rts_next   = 1'b0; // RL7
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State, counter and line outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg  <= ST_IDLE;
      wcnt_reg   <= 13'h0000;
      rts_out    <= 1'b0;
      tx_allow   <= 1'b0;
      tx_timeout <= 1'b0;
    end else begin
      state_reg  <= state_next;
      wcnt_reg   <= wcnt_next;
      rts_out    <= rts_next;
      tx_allow   <= (state_next == ST_SEND); // RL16
      tx_timeout <= tmo_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Receive frame ring buffer
  // ---------------------------------------------------------------------------
  logic [FRAME_W-1:0] mem [0:FRAME_MAX-1];
  logic [7:0] wr_ptr_reg;
  logic [7:0] rd_ptr_reg;
  logic [7:0] count_reg;
  logic       pop;
  logic       eff_prot;
  logic       restart;
  logic       do_push;
  logic       do_over;
  assign pop      = rd_stb && (addr == ADDR_FRAME) && (count_reg != 8'h00);
  assign restart  = wr_stb && (addr == ADDR_RESTART) && wdata[0];
  assign eff_prot = prot_reg || (flim_reg != FRAME_MIN); // RL13
  assign do_push  = rx_frame_valid && (count_reg < flim_reg || (pop && count_reg <= flim_reg)); // RL12
  assign do_over  = rx_frame_valid && !do_push && !eff_prot && count_reg == FRAME_MIN; // RL13

  // Frame storage, not reset so frames survive a startup
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= rx_frame_data;
    end else if (do_over) begin
      mem[rd_ptr_reg] <= rx_frame_data; // RL14
    end
  end

  // Ring pointers and fill count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= 8'h00;
      rd_ptr_reg <= 8'h00;
      count_reg  <= 8'h00;
    end else if (restart && flush_reg) begin
      wr_ptr_reg <= 8'h00; // RL10
      rd_ptr_reg <= 8'h00;
      count_reg  <= 8'h00;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg); // RL11
      end
      if (do_push && !pop) begin
        count_reg <= count_reg + 8'h01;
      end else if (pop && !do_push) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // Sticky lost-frame and timeout flags, set beats clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lost_reg <= 1'b0;
      tmo_reg  <= 1'b0;
    end else begin
      lost_reg <= (rx_frame_valid && !do_push && !do_over) ||
                  (lost_reg && !(wr_stb && addr == ADDR_STATUS && wdata[ST_LOST])); // RL17
      tmo_reg  <= tmo_next || (tmo_reg && !(wr_stb && addr == ADDR_STATUS && wdata[ST_TMO]));
    end
  end

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h00000000;
    end else if (!rd_stb) begin
      rdata <= 32'h00000000;
    end else if (addr == ADDR_CTRL) begin
      rdata <= {25'h0, prot_reg, flush_reg, data8_reg, ifc_reg, mode_reg};
    end else if (addr == ADDR_CHARS) begin
      rdata <= {16'h0000, xoff_reg, xon_reg};
    end else if (addr == ADDR_PWAIT) begin
      rdata <= {19'h0, pwait_reg};
    end else if (addr == ADDR_RTSOFF) begin
      rdata <= {19'h0, rtsoff_reg};
    end else if (addr == ADDR_OUTWAIT) begin
      rdata <= {19'h0, outwait_reg};
    end else if (addr == ADDR_FLIM) begin
      rdata <= {24'h000000, flim_reg};
    end else if (addr == ADDR_STATUS) begin
      rdata <= {17'h0, state_reg, tmo_reg, lost_reg, rts_out, paused_reg, count_reg};
    end else if (addr == ADDR_FRAME) begin
      rdata <= {23'h0, pop, pop ? mem[rd_ptr_reg] : 8'h00}; // RL11
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_rs485_no_flow: assert property (ifc_reg == IFC_RS485 |-> eff_mode == FC_NONE) // RL1
    else $error("flow control active on RS 485");
  a_hw_only_232: assert property ((eff_mode == FC_RTSCTS || eff_mode == FC_AUTO) |-> ifc_reg == IFC_RS232) // RL2
    else $error("hardware handshake off RS 232C");
  a_xoff_holds: assert property (state_reg == ST_SEND && eff_mode == FC_XON && paused_reg && !tx_done // RL16
    |=> state_reg == ST_HOLD && !tx_allow)
    else $error("XOFF did not suspend sending");
  a_none_no_hold: assert property (state_reg == ST_SEND && eff_mode == FC_NONE |=> state_reg != ST_HOLD) // RL6
    else $error("wait applied without handshake mode");
  a_hold_timeout: assert property (state_reg == ST_HOLD && stop_cond && expire // RL5
    |=> state_reg == ST_IDLE && tx_timeout)
    else $error("partner wait expiry not reported");
  a_cts_starts: assert property (state_reg == ST_RTS_WAIT && cts_in |=> tx_allow && rts_out) // RL8
    else $error("CTS did not start transfer");
  a_rts_held: assert property (state_reg == ST_RTS_OFF && !expire |=> rts_out) // RL7
    else $error("RTS dropped before delay");
  a_fill_limit: assert property (count_reg <= FRAME_MAX) // RL12
    else $error("frame count above limit");
  a_full_drop: assert property (rx_frame_valid && !pop && eff_prot && count_reg >= flim_reg // RL17
    |=> $stable(count_reg) && $stable(wr_ptr_reg) && lost_reg)
    else $error("protected full buffer changed");
  a_overwrite_new: assert property (do_over |=> mem[rd_ptr_reg] == $past(rx_frame_data)) // RL14
    else $error("newest frame not kept");
  a_pop_order: assert property (pop && !(restart && flush_reg) |=> rd_ptr_reg == ptr_inc($past(rd_ptr_reg))) // RL11
    else $error("read pointer not advanced");
  a_start_flush: assert property (restart && flush_reg |=> count_reg == 8'h00) // RL10
    else $error("startup did not flush");
  a_start_keep: assert property (restart && !flush_reg && !do_push && !pop |=> $stable(count_reg)) // RL10
    else $error("startup lost frames");

  c_xoff_resume: cover property (state_reg == ST_HOLD ##1 state_reg == ST_SEND);
  c_auto_cycle: cover property (state_reg == ST_RTS_WAIT ##[1:20] state_reg == ST_RTS_OFF);
  c_full_buf: cover property (count_reg == flim_reg && rx_frame_valid);
  c_overwrite: cover property (do_over);
endmodule

/* dv/sfc_line_partner.sv */
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// Line partner: answers request-to-send, sends characters and frames
// -----------------------------------------------------------------------------
module sfc_line_partner (
  input  wire logic                        ref_clk,
  input  wire logic                        rts_out,
  output logic                             cts_in,
  output logic                             rx_char_valid,
  output logic [7:0]                       rx_char,
  output logic                             rx_frame_valid,
  output logic [sfc_pkg::FRAME_W-1:0]      rx_frame_data
);
  logic cts_slow;  // Set by a scenario: partner never grants

  // Idle line values at time zero
  initial begin
    cts_slow = 1'b0;
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    rx_frame_valid = 1'b0;
    rx_frame_data = '0;
  end

  // Clear-to-send follows request-to-send one cycle late
  always_ff @(posedge ref_clk) begin
    cts_in <= rts_out & ~cts_slow;
  end

  // One received character; data scrambled once released
  task automatic send_char(input logic [7:0] c);
    @(posedge ref_clk);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask

  // One received frame of one word
  task automatic send_frame(input logic [sfc_pkg::FRAME_W-1:0] d);
    @(posedge ref_clk);
    rx_frame_data <= d;
    rx_frame_valid <= 1'b1;
    @(posedge ref_clk);
    rx_frame_valid <= 1'b0;
    rx_frame_data <= ~d;
  endtask
endmodule

/* dv/test_sfc_flow_rxbuf.sv */
`timescale 1ns/1ns
module test_sfc_flow_rxbuf;
  import sfc_pkg::*;
  logic        ref_clk, arst_n, wr_stb, rd_stb, tx_start, tx_done;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        rx_char_valid, rx_frame_valid, cts_in, rts_out, tx_allow, tx_timeout;
  logic [7:0]  rx_char;
  logic [FRAME_W-1:0] rx_frame_data;
  int          err_count, samples_checked;

  sfc_flow_rxbuf #(.TICK_CYCLES(10)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_start(tx_start), .tx_done(tx_done),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_frame_valid(rx_frame_valid),
    .rx_frame_data(rx_frame_data), .cts_in(cts_in), .rts_out(rts_out), .tx_allow(tx_allow),
    .tx_timeout(tx_timeout));
  sfc_line_partner partner (.ref_clk(ref_clk), .rts_out(rts_out), .cts_in(cts_in),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_frame_valid(rx_frame_valid),
    .rx_frame_data(rx_frame_data));

  // -----------------------------------------------------------------------------
  // Bus and handshake tasks
  // -----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    chk(rdata & m, exp);
  endtask
  task automatic txp(input logic done);
    @(posedge ref_clk);
    tx_start <= ~done;
    tx_done <= done;
    @(posedge ref_clk);
    tx_start <= 1'b0;
    tx_done <= 1'b0;
  endtask
  // Bounded wait: 0 allow, 1 request-to-send, 2 timeout pulse
  task automatic wait_out(input int sel, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge ref_clk);
      if ((sel == 0 ? tx_allow : sel == 1 ? rts_out : tx_timeout) === lvl) break;
    end
    chk({31'h0, i < lim}, 32'h1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // -----------------------------------------------------------------------------
  // Clock, reset, watchdog
  // -----------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  // Test sequence
  initial begin
    {arst_n, wr_stb, rd_stb, tx_start, tx_done, addr, wdata} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h7F, 32'h70);
    rd_chk(ADDR_CHARS, 32'hFFFF, 32'h1311);
    rd_chk(ADDR_PWAIT, 32'h1FFF, 32'h2);
    rd_chk(ADDR_RTSOFF, 32'h1FFF, 32'h0);
    rd_chk(ADDR_OUTWAIT, 32'h1FFF, 32'h0);
    rd_chk(ADDR_FLIM, 32'hFF, 32'hFA);
    rd_chk(8'h24, 32'hFFFFFFFF, 32'h0);
    wr(ADDR_FLIM, 32'h0);
    rd_chk(ADDR_FLIM, 32'hFF, 32'h1);
    wr(ADDR_FLIM, 32'hFF);
    rd_chk(ADDR_FLIM, 32'hFF, 32'hFA);
    wr(ADDR_PWAIT, 32'h0);
    rd_chk(ADDR_PWAIT, 32'h1FFF, 32'h2);
    wr(ADDR_RTSOFF, 32'hFFFF);
    rd_chk(ADDR_RTSOFF, 32'h1FFF, 32'h1999);
    wr(ADDR_OUTWAIT, 32'hFFFF);
    rd_chk(ADDR_OUTWAIT, 32'h1FFF, 32'h1999);
    wr(ADDR_OUTWAIT, 32'h2);  // Partner answers CTS a cycle late
    wr(ADDR_RTSOFF, 32'h3);
    // Seven data bits: codes masked, XOFF with top bit set still pauses
    wr(ADDR_CTRL, 32'h60);
    wr(ADDR_CHARS, 32'hFFFF);
    rd_chk(ADDR_CHARS, 32'hFFFF, 32'h7F7F);
    wr(ADDR_CHARS, 32'h1311);
    wr(ADDR_CTRL, 32'h61);
    txp(0);
    wait_out(0, 1'b1, 4);
    partner.send_char(8'h93);
    wait_out(0, 1'b0, 6);
    rd_chk(ADDR_STATUS, 32'h100, 32'h100);
    partner.send_char(8'h91);
    wait_out(0, 1'b1, 6);
    partner.send_char(8'h13);
    wait_out(2, 1'b1, 40);
    rd_chk(ADDR_STATUS, 32'h800, 32'h800);
    wr(ADDR_STATUS, 32'h800);
    rd_chk(ADDR_STATUS, 32'h800, 32'h0);
    txp(1);
    // Half-duplex port ignores XOFF
    wr(ADDR_CTRL, 32'h79);
    repeat (3) @(posedge ref_clk);
    txp(0);
    wait_out(0, 1'b1, 4);
    partner.send_char(8'h13);
    repeat (4) @(negedge ref_clk);
    chk({31'h0, tx_allow}, 32'h1);
    txp(1);
    // Automatic mode on four-wire port acts as none
    wr(ADDR_CTRL, 32'h77);
    txp(0);
    wait_out(0, 1'b1, 4);
    chk({31'h0, rts_out}, 32'h0);
    txp(1);
    // Automatic mode on RS 232C, prompt partner, RTS-off delay 3 steps
    wr(ADDR_CTRL, 32'h73);
    repeat (3) @(posedge ref_clk);
    txp(0);
    wait_out(1, 1'b1, 3);
    wait_out(0, 1'b1, 6);
    txp(1);
    repeat (12) @(negedge ref_clk);
    chk({31'h0, rts_out}, 32'h1);
    wait_out(1, 1'b0, 40);
    // Silent partner: wait expires, nothing sent
    wr(ADDR_RTSOFF, 32'h0);
    partner.cts_slow = 1'b1;
    txp(0);
    wait_out(2, 1'b1, 30);
    chk({31'h0, tx_allow}, 32'h0);
    partner.cts_slow = 1'b0;
    // Hardware handshake on RS 232C: CTS low holds sending
    wr(ADDR_CTRL, 32'h72);
    wait_out(1, 1'b1, 3);
    txp(0);
    wait_out(0, 1'b1, 4);
    partner.cts_slow = 1'b1;
    wait_out(0, 1'b0, 4);
    partner.cts_slow = 1'b0;
    wait_out(0, 1'b1, 6);
    txp(1);
    // Frames leave oldest first
    wr(ADDR_CTRL, 32'h70);
    for (int k = 0; k < 3; k++) begin
      partner.send_frame(8'hA1 + 8'(k) * 8'h11);
    end
    rd_chk(ADDR_STATUS, 32'hFF, 32'h3);
    for (int k = 0; k < 3; k++) begin
      rd_chk(ADDR_FRAME, 32'h1FF, 32'h1A1 + 32'(k) * 32'h11);
    end
    rd_chk(ADDR_FRAME, 32'h1FF, 32'h0);
    // Full protected buffer drops the newcomer
    wr(ADDR_FLIM, 32'h2);
    for (int k = 1; k <= 3; k++) begin
      partner.send_frame(8'(k));
    end
    rd_chk(ADDR_STATUS, 32'h4FF, 32'h402);
    for (int k = 1; k <= 2; k++) begin
      rd_chk(ADDR_FRAME, 32'h1FF, 32'h100 + 32'(k));
    end
    wr(ADDR_STATUS, 32'h400);
    // One-frame buffer without protection keeps the newest
    wr(ADDR_FLIM, 32'h1);
    wr(ADDR_CTRL, 32'h30);
    partner.send_frame(8'h55);
    partner.send_frame(8'h66);
    rd_chk(ADDR_FRAME, 32'h1FF, 32'h166);
    rd_chk(ADDR_FRAME, 32'h1FF, 32'h0);
    // Startup with and without flush
    wr(ADDR_FLIM, 32'hFA);
    wr(ADDR_CTRL, 32'h70);
    partner.send_frame(8'h77);
    wr(ADDR_RESTART, 32'h1);
    rd_chk(ADDR_STATUS, 32'hFF, 32'h0);
    wr(ADDR_CTRL, 32'h50);
    partner.send_frame(8'h88);
    wr(ADDR_RESTART, 32'h1);
    rd_chk(ADDR_FRAME, 32'h1FF, 32'h188);
    report_and_stop();
  end
endmodule
